// *** logic/led_drv_pkg.sv ***
package led_drv_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0]  FUNC_CTRL_OFFSET     = 8'h18;
    localparam logic [7:0]  MANUAL_OVR_OFFSET    = 8'h19;
    localparam logic [15:0] FUNC_CTRL_RESET      = 16'h0000;
    localparam logic [15:0] MANUAL_OVR_RESET     = 16'h0000;
    localparam logic [15:0] UNMAPPED_READ        = 16'h0000;
    // ==========================================================
    // Field positions in function control
    localparam int TX_SEL_LO_BIT    = 0;
    localparam int RX_SEL_BIT       = 1;
    localparam int DUP_SEL_LO_BIT   = 2;
    localparam int LINK_MODE_LO_BIT = 3;
    localparam int TX_SEL_HI_BIT    = 6;
    localparam int DUP_SEL_HI_BIT   = 7;
    localparam int BLINK_LO_BIT     = 8;
    localparam int STRETCH_LO_BIT   = 12;
    // ==========================================================
    // Default field codes
    localparam logic [2:0] STRETCH_DEFAULT = 3'h4;
    localparam logic [2:0] BLINK_DEFAULT   = 3'h1;
    // ==========================================================
    // Timing
    localparam int CLK_FREQ_HZ     = 20_000_000;
    localparam int MS_PER_TICK     = 1;
    localparam int CYCLES_PER_MS   = CLK_FREQ_HZ / 1000 * MS_PER_TICK;
    localparam int STRETCH_MIN_MS  = 170;
    localparam int STRETCH_MAX_MS  = 340;
    localparam int BLINK_PERIOD_MS = 84;
    // ==========================================================
    // Output indices and override codes
    localparam int NUM_OUTPUTS = 6;
    localparam int IDX_TEN     = 0;
    localparam int IDX_HUNDRED = 1;
    localparam int IDX_GIG     = 2;
    localparam int IDX_DUPLEX  = 3;
    localparam int IDX_RX      = 4;
    localparam int IDX_TX      = 5;
    localparam logic [1:0] OVR_FOLLOW = 2'h0;
    localparam logic [1:0] OVR_BLINK  = 2'h1;
    localparam logic [1:0] OVR_OFF    = 2'h2;
    localparam logic [1:0] OVR_ON     = 2'h3;
    // Link speed encoding
    typedef enum logic [1:0] {SPEED_10, SPEED_100, SPEED_1000, SPEED_RSVD} speed_t;
endpackage

// *** logic/ms_tick_gen.sv ***
`timescale 1ns/10ps
// Divides the core clock into a one-cycle millisecond enable
module ms_tick_gen #(
    parameter int CYCLES = 20000
) (
    input  wire logic core_clk_i,
    input  wire logic nrst_i,
    output logic      tick_o
);
    localparam int CW = $clog2(CYCLES);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
    logic [CW-1:0] cnt_q;

    // Free-running divider
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_q  <= '0;
            tick_o <= 1'b0;
        end else begin
            tick_o <= (cnt_q == LAST);
            cnt_q  <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
        end
    end
endmodule // ms_tick_gen

// *** logic/pulse_stretcher.sv ***
`timescale 1ns/10ps
// Holds a short event visible for a given number of millisecond ticks
module pulse_stretcher #(
    parameter int W = 9
) (
    input  wire logic         core_clk_i,
    input  wire logic         nrst_i,
    input  wire logic         tick_i,
    input  wire logic         event_i,
    input  wire logic [W-1:0] hold_ms_i,
    output logic              active_o
);
    logic [W-1:0] left_q;

    // Retrigger on every event; an idle gap of one tick drops it early only when hold_ms_i is 0 or 1
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            left_q <= '0;
        end else if (event_i) begin
            left_q <= hold_ms_i;
        end else if (tick_i && left_q != '0) begin
            left_q <= left_q - 1'b1;
        end
    end

    assign active_o = event_i || (left_q != '0);
endmodule // pulse_stretcher

// *** logic/phy_status_led_driver.sv ***
`timescale 1ns/10ps
module phy_status_led_driver
    import led_drv_pkg::*;
(
    input  wire logic                core_clk_i,
    input  wire logic                nrst_i,
    // Register port
    input  wire logic [7:0]          reg_addr_i,
    input  wire logic [15:0]         reg_wdata_i,
    input  wire logic                reg_wr_i,
    input  wire logic                reg_rd_i,
    output logic [15:0]              reg_rdata_o,
    // Status from transceiver core (same clock)
    input  wire logic                link_up_i,
    input  wire led_drv_pkg::speed_t speed_i,
    input  wire logic                full_duplex_i,
    input  wire logic                fiber_i,
    input  wire logic                master_i,
    input  wire logic                mac_to_1000x_i,
    input  wire logic                collision_i,
    input  wire logic                rx_active_i,
    input  wire logic                tx_active_i,
    // Indicator pins, active low
    output logic                     ten_meg_link_out_n_o,
    output logic                     hundred_meg_link_out_n_o,
    output logic                     gigabit_link_out_n_o,
    output logic                     duplex_indicator_out_n_o,
    output logic                     receive_activity_out_n_o,
    output logic                     transmit_activity_out_n_o
);
    import led_drv_pkg::*;

    // ==========================================================
    // Registers
    logic [15:0] func_ctrl_q;
    logic [15:0] manual_ovr_q;
    logic [15:0] func_ctrl_rst;

    assign func_ctrl_rst = FUNC_CTRL_RESET
                           | (16'(STRETCH_DEFAULT) << STRETCH_LO_BIT)
                           | (16'(BLINK_DEFAULT) << BLINK_LO_BIT);

    // Write decode; defaults restore on reset
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            func_ctrl_q <= FUNC_CTRL_RESET
                           | (16'(STRETCH_DEFAULT) << STRETCH_LO_BIT)
                           | (16'(BLINK_DEFAULT) << BLINK_LO_BIT);
        end else if (reg_wr_i && reg_addr_i == FUNC_CTRL_OFFSET) begin
            func_ctrl_q <= reg_wdata_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            manual_ovr_q <= MANUAL_OVR_RESET;
        end else if (reg_wr_i && reg_addr_i == MANUAL_OVR_OFFSET) begin
            manual_ovr_q <= reg_wdata_i;
        end
    end

    // Read data valid the cycle after the strobe; unmapped reads zero
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                FUNC_CTRL_OFFSET:  reg_rdata_o <= func_ctrl_q;
                MANUAL_OVR_OFFSET: reg_rdata_o <= manual_ovr_q;
                default:           reg_rdata_o <= UNMAPPED_READ;
            endcase
        end
    end

    // ==========================================================
    // Field extraction
    logic [2:0] link_mode;
    logic [1:0] dup_sel;
    logic       rx_sel;
    logic [1:0] tx_sel;
    logic [2:0] blink_code;
    logic [2:0] stretch_code;

    assign link_mode    = func_ctrl_q[LINK_MODE_LO_BIT +: 3];
    assign dup_sel      = {func_ctrl_q[DUP_SEL_HI_BIT], func_ctrl_q[DUP_SEL_LO_BIT]};
    assign rx_sel       = func_ctrl_q[RX_SEL_BIT];
    assign tx_sel       = {func_ctrl_q[TX_SEL_HI_BIT], func_ctrl_q[TX_SEL_LO_BIT]};
    assign blink_code   = func_ctrl_q[BLINK_LO_BIT +: 3];
    assign stretch_code = func_ctrl_q[STRETCH_LO_BIT +: 3];

    // ==========================================================
    // Duration tables in milliseconds
    logic [8:0] stretch_ms;
    logic [8:0] blink_half_ms;

    // Stretch code table; default code sits inside the 170-340 ms window
    always_comb begin
        unique case (stretch_code)
            3'h0:    stretch_ms = 9'h000;
            3'h1:    stretch_ms = 9'h015;
            3'h2:    stretch_ms = 9'h02a;
            3'h3:    stretch_ms = 9'h054;
            3'h4:    stretch_ms = 9'(STRETCH_MIN_MS);
            3'h5:    stretch_ms = 9'(STRETCH_MAX_MS);
            3'h6:    stretch_ms = 9'h190;
            default: stretch_ms = 9'h1f4;
        endcase
    end

    // Blink half periods; code 1 gives the 84 ms default period
    always_comb begin
        unique case (blink_code)
            3'h0:    blink_half_ms = 9'h015;
            3'h1:    blink_half_ms = 9'(BLINK_PERIOD_MS / 2);
            3'h2:    blink_half_ms = 9'h054;
            3'h3:    blink_half_ms = 9'h0a8;
            3'h4:    blink_half_ms = 9'h150;
            3'h5:    blink_half_ms = 9'h0fc;
            3'h6:    blink_half_ms = 9'h1a4;
            default: blink_half_ms = 9'h1f8;
        endcase
    end

    // ==========================================================
    // Millisecond tick and blink generator
    logic       ms_tick;
    logic [8:0] blink_cnt_q;
    logic       blink_phase_q;

    ms_tick_gen #(
        .CYCLES (CYCLES_PER_MS)
    ) u_tick (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .tick_o     (ms_tick)
    );

    // One shared square wave for status and manual blinking
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            blink_cnt_q   <= '0;
            blink_phase_q <= 1'b0;
        end else if (ms_tick) begin
            if (blink_cnt_q + 9'h001 >= blink_half_ms) begin
                blink_cnt_q   <= '0;
                blink_phase_q <= ~blink_phase_q;
            end else begin
                blink_cnt_q <= blink_cnt_q + 9'h001;
            end
        end
    end

    // ==========================================================
    // Stretched activity events (only collision, rx, tx)
    logic [2:0] evt_raw;
    logic [2:0] evt_str;

    assign evt_raw = {collision_i, tx_active_i, rx_active_i};

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_str
            pulse_stretcher #(
                .W (9)
            ) u_str (
                .core_clk_i (core_clk_i),
                .nrst_i     (nrst_i),
                .tick_i     (ms_tick),
                .event_i    (evt_raw[g]),
                .hold_ms_i  (stretch_ms),
                .active_o   (evt_str[g])
            );
        end
    endgenerate

    logic rx_evt;
    logic tx_evt;
    logic col_evt;
    logic any_evt;
    assign rx_evt  = evt_str[0];
    assign tx_evt  = evt_str[1];
    assign col_evt = evt_str[2];
    assign any_evt = rx_evt | tx_evt;

    // ==========================================================
    // Status-driven lit levels (1 = lit)
    logic is10;
    logic is100;
    logic is1000;
    logic fib_g;
    logic [5:0] lit;

    assign is10   = link_up_i && speed_i == SPEED_10;
    assign is100  = link_up_i && speed_i == SPEED_100;
    assign is1000 = link_up_i && speed_i == SPEED_1000;
    assign fib_g  = is1000 && fiber_i;

    // Link speed outputs; unlisted modes fall back to direct mode
    always_comb begin
        lit = '0;
        unique case (link_mode)
            3'h1: begin
                lit[IDX_GIG]     = link_up_i;
                lit[IDX_HUNDRED] = is1000 | is100;
                lit[IDX_TEN]     = is1000 | is10;
            end
            3'h2: begin
                lit[IDX_TEN]     = link_up_i;
                lit[IDX_GIG]     = is1000;
                lit[IDX_HUNDRED] = is100;
            end
            3'h3: begin
                lit[IDX_GIG]     = is1000;
                lit[IDX_HUNDRED] = is100;
                lit[IDX_TEN]     = is10 | (is1000 && !fiber_i && master_i);
            end
            3'h4: begin
                lit[IDX_GIG]     = is1000 && !mac_to_1000x_i;
                lit[IDX_HUNDRED] = is100;
                lit[IDX_TEN]     = is10;
            end
            3'h7: begin
                lit[IDX_GIG]     = is1000;
                lit[IDX_HUNDRED] = is100 | fib_g;
                lit[IDX_TEN]     = is10 | (is1000 && !fiber_i && master_i);
            end
            default: begin
                lit[IDX_TEN]     = is10;
                lit[IDX_HUNDRED] = is100;
                lit[IDX_GIG]     = is1000;
            end
        endcase

        // Duplex: in setting 0 collision blinks over the plain duplex level
        unique case (dup_sel)
            2'h0:    lit[IDX_DUPLEX] = col_evt ? blink_phase_q
                                               : full_duplex_i;
            2'h1:    lit[IDX_DUPLEX] = full_duplex_i;
            2'h2:    lit[IDX_DUPLEX] = link_up_i && fiber_i;
            default: lit[IDX_DUPLEX] = 1'b0; // Reserved setting stays dark
        endcase

        // Receive
        if (rx_sel) begin
            lit[IDX_RX] = rx_evt ? blink_phase_q : link_up_i;
        end else begin
            lit[IDX_RX] = rx_evt;
        end

        // Transmit
        unique case (tx_sel)
            2'h0: lit[IDX_TX] = tx_evt;
            2'h1: lit[IDX_TX] = any_evt ? blink_phase_q : link_up_i;
            2'h2: lit[IDX_TX] = any_evt;
            2'h3: lit[IDX_TX] = any_evt && blink_phase_q;
        endcase
    end

    // ==========================================================
    // Manual override and registered active-low pins
    logic [5:0] pin_n_q;

    generate
        for (g = 0; g < NUM_OUTPUTS; g++) begin : g_pin
            // Override beats status whatever the link does
            always_ff @(posedge core_clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    pin_n_q[g] <= 1'b1;
                end else begin
                    unique case (manual_ovr_q[2*g +: 2])
                        OVR_ON:    pin_n_q[g] <= 1'b0;
                        OVR_OFF:   pin_n_q[g] <= 1'b1;
                        OVR_BLINK: pin_n_q[g] <= ~blink_phase_q;
                        default:   pin_n_q[g] <= ~lit[g];
                    endcase
                end
            end
        end
    endgenerate

    assign ten_meg_link_out_n_o      = pin_n_q[IDX_TEN];
    assign hundred_meg_link_out_n_o  = pin_n_q[IDX_HUNDRED];
    assign gigabit_link_out_n_o      = pin_n_q[IDX_GIG];
    assign duplex_indicator_out_n_o  = pin_n_q[IDX_DUPLEX];
    assign receive_activity_out_n_o  = pin_n_q[IDX_RX];
    assign transmit_activity_out_n_o = pin_n_q[IDX_TX];
endmodule // phy_status_led_driver

// *** verification/phy_status_led_driver_sva.sv ***
`timescale 1ns/10ps
module led_drv_chk
    import led_drv_pkg::*;
(
    input wire logic                core_clk_i,
    input wire logic                nrst_i,
    input wire logic [7:0]          reg_addr_i,
    input wire logic [15:0]         reg_wdata_i,
    input wire logic                reg_wr_i,
    input wire logic                reg_rd_i,
    input wire logic [15:0]         reg_rdata_o,
    input wire logic                link_up_i,
    input wire led_drv_pkg::speed_t speed_i,
    input wire logic                full_duplex_i,
    input wire logic                rx_active_i,
    input wire logic                tx_active_i,
    input wire logic                ten_meg_link_out_n_o,
    input wire logic                hundred_meg_link_out_n_o,
    input wire logic                gigabit_link_out_n_o,
    input wire logic                duplex_indicator_out_n_o,
    input wire logic                receive_activity_out_n_o,
    input wire logic                transmit_activity_out_n_o
);
    logic [15:0] ctrl_q;
    logic [15:0] ovr_q;
    logic [5:0]  on_v;
    logic [5:0]  off_v;
    logic [5:0]  fol_v;
    wire  [5:0]  pin_n = {transmit_activity_out_n_o, receive_activity_out_n_o,
                          duplex_indicator_out_n_o, gigabit_link_out_n_o,
                          hundred_meg_link_out_n_o, ten_meg_link_out_n_o};
    wire  [2:0]  mode = ctrl_q[5:3];
    // Conditions carry reset so that history from inside reset never counts
    wire dn  = nrst_i && !link_up_i && fol_v[2:0] == 3'h7;
    wire t10 = nrst_i && link_up_i && speed_i == SPEED_10 && mode == 3'h0 && fol_v[0];
    wire g1  = nrst_i && link_up_i && speed_i != SPEED_RSVD && mode == 3'h1 && fol_v[2];
    wire rxd = nrst_i && rx_active_i && !ctrl_q[1] && fol_v[4];
    wire txd = nrst_i && tx_active_i && !ctrl_q[6] && !ctrl_q[0] && fol_v[5];
    wire dpf = nrst_i && full_duplex_i && ctrl_q[2] && !ctrl_q[7] && fol_v[3];
    // ==========================================
    // Shadow copies of the two registers
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_q <= 16'h4100;
            ovr_q  <= 16'h0000;
        end else if (reg_wr_i && reg_addr_i == FUNC_CTRL_OFFSET) begin
            ctrl_q <= reg_wdata_i;
        end else if (reg_wr_i && reg_addr_i == MANUAL_OVR_OFFSET) begin
            ovr_q <= reg_wdata_i;
        end
    end
    // Per-output override decode
    always_comb begin
        for (int g = 0; g < 6; g++) begin
            on_v[g]  = nrst_i && ovr_q[2*g+:2] == OVR_ON;
            off_v[g] = nrst_i && ovr_q[2*g+:2] == OVR_OFF;
            fol_v[g] = ovr_q[2*g+:2] == OVR_FOLLOW;
        end
    end
    // ==========================================
    // Checks; three samples allow for the one-cycle pin latency
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    AST_RST_DARK: assert property ($rose(nrst_i) |-> pin_n == 6'h3f)
        else $error("pins not dark after reset");
    AST_OVR_ON: assert property ((on_v & $past(on_v) & $past(on_v, 2) & pin_n) == 6'h00)
        else $error("forced-on pin not low");
    AST_OVR_OFF: assert property ((off_v & $past(off_v) & $past(off_v, 2) & ~pin_n) == 6'h00)
        else $error("forced-off pin not high");
    AST_LINK_DOWN: assert property (dn && $past(dn) && $past(dn, 2) |-> pin_n[2:0] == 3'h7)
        else $error("link pins lit while link down");
    AST_DIRECT_TEN: assert property (t10 && $past(t10) && $past(t10, 2) |-> !pin_n[0])
        else $error("ten pin dark on ten link");
    AST_GLOBAL_GIG: assert property (g1 && $past(g1) && $past(g1, 2) |-> !pin_n[2])
        else $error("gigabit pin not global link");
    AST_RX_DIRECT: assert property (rxd && $past(rxd) && $past(rxd, 2) |-> !pin_n[4])
        else $error("receive pin dark while receiving");
    AST_TX_DIRECT: assert property (txd && $past(txd) && $past(txd, 2) |-> !pin_n[5])
        else $error("transmit pin dark while sending");
    AST_DUP_PLAIN: assert property (dpf && $past(dpf) && $past(dpf, 2) |-> !pin_n[3])
        else $error("duplex pin dark on full duplex");
    AST_CTRL_RD: assert property (reg_rd_i && reg_addr_i == FUNC_CTRL_OFFSET
        |=> reg_rdata_o == $past(ctrl_q)) else $error("control read mismatch");
    AST_UNMAPPED_RD: assert property (reg_rd_i && reg_addr_i != FUNC_CTRL_OFFSET
        && reg_addr_i != MANUAL_OVR_OFFSET |=> reg_rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    AST_RD_HOLD: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved without a read");
endmodule // led_drv_chk

bind phy_status_led_driver led_drv_chk u_chk (.core_clk_i, .nrst_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .link_up_i, .speed_i,
    .full_duplex_i, .rx_active_i, .tx_active_i, .ten_meg_link_out_n_o,
    .hundred_meg_link_out_n_o, .gigabit_link_out_n_o, .duplex_indicator_out_n_o,
    .receive_activity_out_n_o, .transmit_activity_out_n_o);

// *** verification/led_board_model.sv ***
`timescale 1ns/10ps
// Board lamps: each glows while its cathode pin is pulled low
module led_board_model (
    input  wire logic [5:0] pin_n_i,
    output logic [5:0]      lit_o
);
    // Pull-up to supply keeps a high or floating pin dark
    always_comb begin
        for (int g = 0; g < 6; g++) begin
            lit_o[g] = (pin_n_i[g] === 1'b0);
        end
    end
endmodule // led_board_model

// *** verification/phy_status_led_driver_tb.sv ***
`timescale 1ns/10ps
module phy_status_led_driver_tb;
    import led_drv_pkg::*;
    logic        core_clk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic [7:0]  reg_addr_i = 8'h00;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    logic [15:0] reg_rdata_o;
    logic        link_up_i = 1'b0;
    speed_t      speed_i = SPEED_10;
    logic        full_duplex_i = 1'b0;
    logic        fiber_i = 1'b0;
    logic        master_i = 1'b0;
    logic        mac_to_1000x_i = 1'b0;
    logic        collision_i = 1'b0;
    logic        rx_active_i = 1'b0;
    logic        tx_active_i = 1'b0;
    wire  [5:0]  pin_n;
    logic [5:0]  lit;
    int          bad_count = 0;
    int          check_count = 0;
    logic [2:0]  modes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};

    phy_status_led_driver u_dut (.core_clk_i, .nrst_i, .reg_addr_i, .reg_wdata_i,
        .reg_wr_i, .reg_rd_i, .reg_rdata_o, .link_up_i, .speed_i, .full_duplex_i,
        .fiber_i, .master_i, .mac_to_1000x_i, .collision_i, .rx_active_i, .tx_active_i,
        .ten_meg_link_out_n_o(pin_n[0]), .hundred_meg_link_out_n_o(pin_n[1]),
        .gigabit_link_out_n_o(pin_n[2]), .duplex_indicator_out_n_o(pin_n[3]),
        .receive_activity_out_n_o(pin_n[4]), .transmit_activity_out_n_o(pin_n[5]));
    led_board_model u_board (.pin_n_i(pin_n), .lit_o(lit));

    // ==========================================
    // Clock and shared tasks
    initial forever #25 core_clk_i = ~core_clk_i;

    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    // Data stands from the cycle after the strobe and holds until the next read
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk("read data", e, reg_rdata_o);
    endtask
    // Off-edge sampling once the pins have settled
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    function automatic logic [2:0] exp_link(input logic [2:0] m, input int cs);
        if (cs == 0) return 3'h0;
        if (cs == 1) return (m == 3'h1) ? 3'h5 : 3'h1;
        if (cs == 2) return (m == 3'h1) ? 3'h6 : (m == 3'h2) ? 3'h3 : 3'h2;
        case (m)
            3'h1: return 3'h7;
            3'h2: return 3'h5;
            3'h3: return (cs == 4) ? 3'h5 : 3'h4;
            3'h4: return (cs == 6) ? 3'h0 : 3'h4;
            3'h7: return (cs == 4) ? 3'h5 : (cs >= 5) ? 3'h6 : 3'h4;
            default: return 3'h4;
        endcase
    endfunction
    task automatic act(input logic [15:0] c, input logic l, r, t, input int i, input logic e);
        wr(FUNC_CTRL_OFFSET, c);
        link_up_i <= l;
        rx_active_i <= r;
        tx_active_i <= t;
        settle(4);
        chk("activity pin", {15'h0, e}, {15'h0, lit[i]});
    endtask
    task automatic dup(input logic [15:0] c, input logic fd, fb, e);
        wr(FUNC_CTRL_OFFSET, c);
        full_duplex_i <= fd;
        fiber_i <= fb;
        settle(4);
        chk("duplex pin", {15'h0, e}, {15'h0, lit[IDX_DUPLEX]});
    endtask

    // ==========================================
    // Scenarios
    task automatic t_reset();
        settle(4);
        chk("pins in reset", 16'h0, {10'h0, lit});
        nrst_i <= 1'b1;
        rd(FUNC_CTRL_OFFSET, 16'h4100);
        rd(MANUAL_OVR_OFFSET, 16'h0000);
        rd(8'h20, 16'h0000);
        wr(FUNC_CTRL_OFFSET, 16'h7ff5);
        wr(8'h20, 16'hffff);
        rd(FUNC_CTRL_OFFSET, 16'h7ff5);
        rd(MANUAL_OVR_OFFSET, 16'h0000);
        $display("reset and register test done");
    endtask
    task automatic t_link();
        foreach (modes[k]) begin
            wr(FUNC_CTRL_OFFSET, 16'h4100 | {10'h0, modes[k], 3'h0});
            for (int cs = 0; cs < 7; cs++) begin
                @(posedge core_clk_i);
                link_up_i <= (cs != 0);
                speed_i <= (cs == 1) ? SPEED_10 : (cs == 2) ? SPEED_100 : SPEED_1000;
                master_i <= (cs == 4);
                fiber_i <= (cs >= 5);
                mac_to_1000x_i <= (cs == 6);
                settle(4);
                chk("link pins", {13'h0, exp_link(modes[k], cs)}, {13'h0, lit[2:0]});
            end
        end
        $display("link mode test done");
    endtask
    task automatic t_override();
        wr(MANUAL_OVR_OFFSET, 16'h0fff);
        for (int l = 0; l < 2; l++) begin
            link_up_i <= l[0];
            settle(4);
            chk("forced on", 16'h003f, {10'h0, lit});
        end
        wr(MANUAL_OVR_OFFSET, 16'h0aaa);
        full_duplex_i <= 1'b1;
        speed_i <= SPEED_10;
        settle(4);
        chk("forced off", 16'h0000, {10'h0, lit});
        wr(FUNC_CTRL_OFFSET, 16'h4100);
        wr(MANUAL_OVR_OFFSET, 16'h000b);
        speed_i <= SPEED_100;
        settle(4);
        chk("mixed override", 16'h0001, {13'h0, lit[2:0]});
        wr(MANUAL_OVR_OFFSET, 16'h0000);
        $display("override test done");
    endtask
    task automatic t_duplex();
        dup(16'h4104, 1'b1, 1'b0, 1'b1);
        dup(16'h4104, 1'b0, 1'b0, 1'b0);
        dup(16'h4180, 1'b0, 1'b1, 1'b1);
        dup(16'h4180, 1'b1, 1'b0, 1'b0);
        dup(16'h4184, 1'b1, 1'b1, 1'b0);
        dup(16'h4100, 1'b1, 1'b0, 1'b1);
        $display("duplex test done");
    endtask
    // Shortest stretch code so dark phases follow quickly
    task automatic t_activity();
        act(16'h0100, 1'b0, 1'b1, 1'b0, IDX_RX, 1'b1);
        act(16'h0100, 1'b0, 1'b0, 1'b0, IDX_RX, 1'b0);
        act(16'h0102, 1'b1, 1'b0, 1'b0, IDX_RX, 1'b1);
        act(16'h0102, 1'b0, 1'b0, 1'b0, IDX_RX, 1'b0);
        act(16'h0100, 1'b0, 1'b0, 1'b1, IDX_TX, 1'b1);
        act(16'h0100, 1'b0, 1'b0, 1'b0, IDX_TX, 1'b0);
        act(16'h0140, 1'b0, 1'b1, 1'b0, IDX_TX, 1'b1);
        act(16'h0101, 1'b1, 1'b0, 1'b0, IDX_TX, 1'b1);
        act(16'h0101, 1'b0, 1'b0, 1'b0, IDX_TX, 1'b0);
        act(16'h0141, 1'b0, 1'b0, 1'b0, IDX_TX, 1'b0);
        $display("activity test done");
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ==========================================
    // Main sequence and watchdog
    initial begin
        t_reset();
        t_link();
        t_override();
        t_duplex();
        t_activity();
        wrap_up();
    end
    initial begin
        #(20000 * 50);
        bad_count++;
        wrap_up();
    end
endmodule // phy_status_led_driver_tb
